/* File: hdl/phy_event_regs_pkg.sv */
// Package: register offsets, field positions and reset values shared by the
// event and carkit register block.
// Assumes a six-bit register address from the interface register port.
`default_nettype none
package phy_event_regs_pkg;
  // Number of comparator sources watched for edges
  localparam int NUM_SRC = 5;
  // Source bit positions
  localparam int SRC_HOST_DISC = 0;
  localparam int SRC_VBUS_VALID = 1;
  localparam int SRC_SESS_VALID = 2;
  localparam int SRC_SESS_END = 3;
  localparam int SRC_ID_GND = 4;
  // Register offsets; enable, scratch and carkit bases take write address, +1 set, +2 clear
  localparam logic [5:0] ADDR_RISE_EN = 6'h0D;
  localparam logic [5:0] ADDR_FALL_EN = 6'h10;
  localparam logic [5:0] ADDR_STATUS = 6'h13;
  localparam logic [5:0] ADDR_LATCH = 6'h14;
  localparam logic [5:0] ADDR_DEBUG = 6'h15;
  localparam logic [5:0] ADDR_SCRATCH = 6'h16;
  localparam logic [5:0] ADDR_CARKIT = 6'h19;
  // Offsets of the set and clear aliases from a base address
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_CLEAR = 2'h2;
  // Reset values
  localparam logic [4:0] RISE_EN_RESET = 5'h1F;
  localparam logic [4:0] FALL_EN_RESET = 5'h1F;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [7:0] CARKIT_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Writable bits of the carkit control register
  localparam logic [7:0] CARKIT_WR_MASK = 8'h0E;
  localparam int CK_ID_GND_DRV = 1;
  localparam int CK_TX_ROUTE = 2;
  localparam int CK_RX_ROUTE = 3;
  // Synchroniser bank layout: sources, line state, UART tx, D-plus
  localparam int SYNC_WIDTH = 9;
  localparam int SYNC_LINE0 = 5;
  localparam int SYNC_LINE1 = 6;
  localparam int SYNC_TXD = 7;
  localparam int SYNC_DP = 8;
endpackage
`default_nettype wire

/* File: hdl/sync_bank.sv */
// Two-flop synchroniser bank for pin and comparator levels.
// Assumes inputs are quasi-static levels from outside the clock domain.
`default_nettype none
module sync_bank #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule
`default_nettype wire

/* File: hdl/phy_event_and_carkit_regs.sv */
// Comparator edge-event enables, status, read-to-clear latch, line-state
// debug, scratch byte and carkit UART routing control.
// Assumes the interface register port delivers single-cycle read and write
// strobes on clk; comparator and pin levels arrive asynchronously.
`default_nettype none
module phy_event_and_carkit_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic hostMode,
  input wire logic hostDisconnectLevel,
  input wire logic vbusValidLevel,
  input wire logic sessionValidLevel,
  input wire logic sessionEndLevel,
  input wire logic idGrounded,
  input wire logic [1:0] lineStateIn,
  input wire logic uartTxIn,
  input wire logic dpLevelIn,
  input wire logic accessoryUartSelect,
  input wire logic carkitExit,
  output logic dmOut,
  output logic dmOe,
  output logic data1Out,
  output logic data1Oe,
  output logic idPinGroundDrive,
  output logic accessoryUartSelectClear,
  output logic eventPending
);
  localparam int N = phy_event_regs_pkg::NUM_SRC;

  logic [phy_event_regs_pkg::SYNC_WIDTH-1:0] syncIn;
  logic [phy_event_regs_pkg::SYNC_WIDTH-1:0] syncLevels;
  logic [N-1:0] srcLevel;
  logic [N-1:0] prevLevel_reg;
  logic [N-1:0] prevLevel_next;
  logic [2:0] primed_reg;
  logic [2:0] primed_next;
  logic [N-1:0] riseEdge;
  logic [N-1:0] fallEdge;
  logic [N-1:0] srcEvent;
  logic [N-1:0] riseEn_reg;
  logic [N-1:0] riseEn_next;
  logic [N-1:0] fallEn_reg;
  logic [N-1:0] fallEn_next;
  logic [N-1:0] latch_reg;
  logic [N-1:0] latch_next;
  logic [7:0] scratch_reg;
  logic [7:0] scratch_next;
  logic [7:0] carkit_reg;
  logic [7:0] carkit_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  logic rdValid_reg;
  logic rdValid_next;
  logic dmOut_reg;
  logic dmOut_next;
  logic dmOe_reg;
  logic dmOe_next;
  logic data1Out_reg;
  logic data1Out_next;
  logic data1Oe_reg;
  logic data1Oe_next;
  logic idDrv_reg;
  logic idDrv_next;
  logic selClear_reg;
  logic selClear_next;
  logic pending_reg;
  logic pending_next;
  logic [1:0] riseOp;
  logic [1:0] fallOp;
  logic [1:0] scratchOp;
  logic [1:0] carkitOp;
  logic riseHit;
  logic fallHit;
  logic scratchHit;
  logic carkitHit;
  logic latchRead;

  // Apply a write, set or clear access to a register value
  function automatic logic [7:0] applyAccess(input logic [7:0] cur,
                                             input logic [1:0] op,
                                             input logic [7:0] data);
    logic [7:0] res;
    res = cur;
    case (op)
      phy_event_regs_pkg::OP_WRITE: res = data;
      phy_event_regs_pkg::OP_SET: res = cur | data;
      phy_event_regs_pkg::OP_CLEAR: res = cur & ~data;
      default: res = cur;
    endcase
    return res;
  endfunction

  // True when addr is base, base+1 or base+2; op gives which alias
  function automatic logic inTriple(input logic [5:0] addr,
                                    input logic [5:0] base);
    return (addr >= base) && (addr <= base + 6'h02);
  endfunction

  // Gather every asynchronous level into one synchroniser bank
  assign syncIn = {dpLevelIn, uartTxIn, lineStateIn, idGrounded,
                   sessionEndLevel, sessionValidLevel, vbusValidLevel,
                   hostDisconnectLevel};

  sync_bank #(
    .WIDTH(phy_event_regs_pkg::SYNC_WIDTH)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .asyncIn(syncIn),
    .syncOut(syncLevels)
  );

  assign srcLevel = syncLevels[N-1:0];

  // Per-source edge detection and masking
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_src
      logic hostGate;
      // Host-disconnect only produces events in host mode
      if (gi == phy_event_regs_pkg::SRC_HOST_DISC) begin : g_host
        assign hostGate = hostMode;
      end else begin : g_other
        assign hostGate = 1'b1;
      end
      assign riseEdge[gi] = primed_reg[2] & srcLevel[gi] & ~prevLevel_reg[gi];
      assign fallEdge[gi] = primed_reg[2] & ~srcLevel[gi] & prevLevel_reg[gi];
      assign srcEvent[gi] = hostGate &
                            ((riseEdge[gi] & riseEn_reg[gi]) |
                             (fallEdge[gi] & fallEn_reg[gi]));
    end
  endgenerate

  // Address decode for the write, set and clear aliases
  always_comb begin
    riseHit = regWrite & inTriple(regAddr, phy_event_regs_pkg::ADDR_RISE_EN);
    fallHit = regWrite & inTriple(regAddr, phy_event_regs_pkg::ADDR_FALL_EN);
    scratchHit = regWrite &
                 inTriple(regAddr, phy_event_regs_pkg::ADDR_SCRATCH);
    carkitHit = regWrite & inTriple(regAddr, phy_event_regs_pkg::ADDR_CARKIT);
    riseOp = 2'(regAddr - phy_event_regs_pkg::ADDR_RISE_EN);
    fallOp = 2'(regAddr - phy_event_regs_pkg::ADDR_FALL_EN);
    scratchOp = 2'(regAddr - phy_event_regs_pkg::ADDR_SCRATCH);
    carkitOp = 2'(regAddr - phy_event_regs_pkg::ADDR_CARKIT);
    latchRead = regRead & (regAddr == phy_event_regs_pkg::ADDR_LATCH);
  end

  // Next values of the edge history, enables, latch and control bytes
  always_comb begin
    logic [7:0] tmp;
    tmp = 8'h00;
    // Arm edges only once the synchroniser holds real levels, so the
    // flush after reset makes no false edge
    prevLevel_next = srcLevel;
    primed_next = {primed_reg[1:0], 1'b1};
    riseEn_next = riseEn_reg;
    fallEn_next = fallEn_reg;
    scratch_next = scratch_reg;
    carkit_next = carkit_reg;
    if (riseHit) begin
      tmp = applyAccess({3'h0, riseEn_reg}, riseOp, regWrData);
      riseEn_next = tmp[N-1:0];
    end
    if (fallHit) begin
      tmp = applyAccess({3'h0, fallEn_reg}, fallOp, regWrData);
      fallEn_next = tmp[N-1:0];
    end
    if (scratchHit) begin
      scratch_next = applyAccess(scratch_reg, scratchOp, regWrData);
    end
    if (carkitHit) begin
      tmp = applyAccess(carkit_reg, carkitOp, regWrData);
      carkit_next = tmp & phy_event_regs_pkg::CARKIT_WR_MASK;
    end
    // Read clears, but a same-cycle event wins over the clear
    latch_next = (latchRead ? {N{1'b0}} : latch_reg)
                 | srcEvent;
    pending_next = |latch_next;
  end

  // Read multiplexer; unmapped addresses return zero
  always_comb begin
    rdData_next = rdData_reg;
    rdValid_next = regRead;
    if (regRead) begin
      rdData_next = phy_event_regs_pkg::READ_ZERO;
      if (inTriple(regAddr, phy_event_regs_pkg::ADDR_RISE_EN)) begin
        rdData_next = {3'h0, riseEn_reg};
      end else if (inTriple(regAddr, phy_event_regs_pkg::ADDR_FALL_EN)) begin
        rdData_next = {3'h0, fallEn_reg};
      end else if (regAddr == phy_event_regs_pkg::ADDR_STATUS) begin
        rdData_next = {3'h0, srcLevel};
      end else if (regAddr == phy_event_regs_pkg::ADDR_LATCH) begin
        rdData_next = {3'h0, latch_reg};
      end else if (regAddr == phy_event_regs_pkg::ADDR_DEBUG) begin
        rdData_next = {6'h00,
                       syncLevels[phy_event_regs_pkg::SYNC_LINE1],
                       syncLevels[phy_event_regs_pkg::SYNC_LINE0]};
      end else if (inTriple(regAddr, phy_event_regs_pkg::ADDR_SCRATCH)) begin
        rdData_next = scratch_reg;
      end else if (inTriple(regAddr, phy_event_regs_pkg::ADDR_CARKIT)) begin
        rdData_next = carkit_reg;
      end
    end
  end

  // UART routing and ID drive outputs
  always_comb begin
    idDrv_next = carkit_reg[phy_event_regs_pkg::CK_ID_GND_DRV];
    dmOe_next = carkit_reg[phy_event_regs_pkg::CK_TX_ROUTE];
    dmOut_next = syncLevels[phy_event_regs_pkg::SYNC_TXD];
    if (carkit_reg[phy_event_regs_pkg::CK_RX_ROUTE]) begin
      data1Out_next = syncLevels[phy_event_regs_pkg::SYNC_DP];
    end else begin
      data1Out_next = 1'b1;
    end
    // Routing is settled before the link selects carkit mode
    data1Oe_next = accessoryUartSelect;
    // Request clear of the mode bit when carkit operation ends
    selClear_next = carkitExit & accessoryUartSelect;
  end

  // Register stage for all state and outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      prevLevel_reg <= '0;
      primed_reg <= '0;
      riseEn_reg <= phy_event_regs_pkg::RISE_EN_RESET;
      fallEn_reg <= phy_event_regs_pkg::FALL_EN_RESET;
      latch_reg <= '0;
      scratch_reg <= phy_event_regs_pkg::SCRATCH_RESET;
      carkit_reg <= phy_event_regs_pkg::CARKIT_RESET;
      rdData_reg <= phy_event_regs_pkg::READ_ZERO;
      rdValid_reg <= 1'b0;
      dmOut_reg <= 1'b0;
      dmOe_reg <= 1'b0;
      data1Out_reg <= 1'b1;
      data1Oe_reg <= 1'b0;
      idDrv_reg <= 1'b0;
      selClear_reg <= 1'b0;
      pending_reg <= 1'b0;
    end else begin
      prevLevel_reg <= prevLevel_next;
      primed_reg <= primed_next;
      riseEn_reg <= riseEn_next;
      fallEn_reg <= fallEn_next;
      latch_reg <= latch_next;
      scratch_reg <= scratch_next;
      carkit_reg <= carkit_next;
      rdData_reg <= rdData_next;
      rdValid_reg <= rdValid_next;
      dmOut_reg <= dmOut_next;
      dmOe_reg <= dmOe_next;
      data1Out_reg <= data1Out_next;
      data1Oe_reg <= data1Oe_next;
      idDrv_reg <= idDrv_next;
      selClear_reg <= selClear_next;
      pending_reg <= pending_next;
    end
  end

  // Outputs straight from flops
  assign regRdData = rdData_reg;
  assign regRdValid = rdValid_reg;
  assign dmOut = dmOut_reg;
  assign dmOe = dmOe_reg;
  assign data1Out = data1Out_reg;
  assign data1Oe = data1Oe_reg;
  assign idPinGroundDrive = idDrv_reg;
  assign accessoryUartSelectClear = selClear_reg;
  assign eventPending = pending_reg;
endmodule
`default_nettype wire

/* File: verif/phy_event_regs_checker.sv */
// Checker: port-level timing of the event and carkit register block.
// Assumes it is bound to the block's top module, one clock domain.
`default_nettype none
module phy_event_regs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic data1Out,
  input wire logic idPinGroundDrive,
  input wire logic accessoryUartSelect,
  input wire logic carkitExit,
  input wire logic accessoryUartSelectClear,
  input wire logic eventPending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Read data shape and pairing with the pending flag
  property p_status;
    regRead && regAddr == 6'h13 |=> regRdValid && regRdData[7:5] == 3'h0;
  endproperty
  a_status: assert property (p_status) else $error("bad status");
  property p_latch;
    regRead && regAddr == 6'h14 |=> regRdData[7:5] == 3'h0 &&
      ((regRdData[4:0] != 5'h00) == $past(eventPending));
  endproperty
  a_latch: assert property (p_latch) else $error("bad latch");
  property p_hold;
    eventPending && !(regRead && regAddr == 6'h14) |=> eventPending;
  endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_carkit;
    regRead && regAddr inside {6'h19, 6'h1A, 6'h1B} |=>
      !regRdData[0] && regRdData[7:4] == 4'h0;
  endproperty
  a_carkit: assert property (p_carkit) else $error("bad carkit");
  // Pin effects of carkit control writes, carkit exit clear and scratch readback
  property p_id_grounded;
    regWrite && regAddr == 6'h1A && regWrData[1] |-> ##[1:2] idPinGroundDrive;
  endproperty
  a_id_grounded: assert property (p_id_grounded) else $error("id not driven");
  property p_rxoff;
    regWrite && regAddr == 6'h19 && !regWrData[3] ##1 !regWrite
      |=> ##[0:1] data1Out;
  endproperty
  a_rxoff: assert property (p_rxoff) else $error("data1 not high");
  property p_exit;
    carkitExit && accessoryUartSelect |=> accessoryUartSelectClear;
  endproperty
  a_exit: assert property (p_exit) else $error("no mode clear");
  property p_scratch;
    regWrite && regAddr == 6'h16 ##1 !regWrite ##1 regRead && !regWrite &&
      regAddr == 6'h16 |=> regRdData == $past(regWrData, 3);
  endproperty
  a_scratch: assert property (p_scratch) else $error("bad scratch");
endmodule
bind phy_event_and_carkit_regs phy_event_regs_checker chk (.clk, .rst,
  .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .regRdValid,
  .data1Out, .idPinGroundDrive, .accessoryUartSelect, .carkitExit,
  .accessoryUartSelectClear, .eventPending);
`default_nettype wire

/* File: verif/link_carkit_model.sv */
// Link model: holds the carkit mode bit that the link sets.
// Assumes the bench programs routing before it raises enterReq.
`default_nettype none
module link_carkit_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic enterReq,
  input wire logic accessoryUartSelectClear,
  output logic accessoryUartSelect
);
  timeunit 1ns;
  timeprecision 1ps;
  logic modeSel_reg;
  logic modeSel_next;
  // Set on request, dropped on the device's clear pulse
  always_comb begin
    modeSel_next = modeSel_reg;
    if (enterReq) modeSel_next = 1'b1;
    if (accessoryUartSelectClear) modeSel_next = 1'b0;
  end
  always_ff @(posedge clk) modeSel_reg <= rst ? 1'b0 : modeSel_next;
  assign accessoryUartSelect = modeSel_reg;
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Testbench: register tests, comparator events and carkit routing.
// Assumes the read strobe answers one cycle later on regRdData.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [5:0] regAddr = 6'h00;
  logic [7:0] regWrData = 8'h00, rdVal, v, regRdData;
  logic hostMode = 1'b1, uartTxIn = 1'b0, dpLevelIn = 1'b0;
  logic carkitExit = 1'b0, enterReq = 1'b0;
  logic [4:0] srcLevel = 5'h0A;
  logic [1:0] lineStateIn = 2'h2;
  logic regRdValid, dmOut, dmOe, data1Out, data1Oe, idPinGroundDrive;
  logic accessoryUartSelect, accessoryUartSelectClear, eventPending;
  int err_total = 0, comparisons = 0, cycles = 0;
  logic [5:0] base [4] = '{6'h0D, 6'h10, 6'h16, 6'h19};
  logic [7:0] mask [4] = '{8'h1F, 8'h1F, 8'hFF, 8'h0E};
  always #12.5 clk = ~clk;
  phy_event_and_carkit_regs DUT (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .regRdValid(regRdValid), .hostMode(hostMode),
    .hostDisconnectLevel(srcLevel[0]), .vbusValidLevel(srcLevel[1]),
    .sessionValidLevel(srcLevel[2]), .sessionEndLevel(srcLevel[3]),
    .idGrounded(srcLevel[4]), .lineStateIn(lineStateIn),
    .uartTxIn(uartTxIn), .dpLevelIn(dpLevelIn),
    .accessoryUartSelect(accessoryUartSelect), .carkitExit(carkitExit),
    .dmOut(dmOut), .dmOe(dmOe), .data1Out(data1Out), .data1Oe(data1Oe),
    .idPinGroundDrive(idPinGroundDrive),
    .accessoryUartSelectClear(accessoryUartSelectClear),
    .eventPending(eventPending));
  link_carkit_model link (.clk(clk), .rst(rst), .enterReq(enterReq),
    .accessoryUartSelectClear(accessoryUartSelectClear),
    .accessoryUartSelect(accessoryUartSelect));
  // Verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run;
    end
  end
  // Compare, register access and wait helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(posedge clk);
    #1 regWrite = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    #1 regAddr = a;
    regRead = 1'b1;
    @(posedge clk);
    #1 regRead = 1'b0;
    rdVal = regRdData;
    chk({7'h00, regRdValid}, 8'h01);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    rd(a);
    chk(rdVal, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Test sequence
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    rdc(6'h0D, 8'h1F);
    rdc(6'h10, 8'h1F);
    rdc(6'h16, 8'h00);
    rdc(6'h19, 8'h00);
    rdc(6'h13, {3'h0, srcLevel});
    rdc(6'h14, 8'h00);
    wr(6'h13, 8'hFF);
    rdc(6'h13, {3'h0, srcLevel});
    wr(6'h15, 8'hFF);
    rdc(6'h15, 8'h02);
    wr(6'h3F, 8'hFF);
    rdc(6'h3F, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(base[i], 8'hA5);
      rdc(base[i], 8'hA5 & mask[i]);
      wr(base[i] + 6'h01, 8'h5A);
      rdc(base[i] + 6'h02, mask[i]);
      wr(base[i] + 6'h02, 8'h0F);
      rdc(base[i] + 6'h01, 8'hF0 & mask[i]);
      wr(base[i], (i < 2) ? 8'h1F : 8'h00);
    end
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      srcLevel[i] = ~srcLevel[i];
      idle(6);
      chk({7'h0, eventPending}, 8'h01);
      rdc(6'h14, 8'h01 << i);
      chk({7'h0, eventPending}, 8'h00);
      srcLevel[i] = ~srcLevel[i];
      idle(6);
      rdc(6'h14, 8'h01 << i);
    end
    wr(6'h0D, 8'h00);
    wr(6'h10, 8'h00);
    srcLevel = ~srcLevel;
    idle(6);
    srcLevel = ~srcLevel;
    idle(6);
    rdc(6'h14, 8'h00);
    wr(6'h0D, 8'h1F);
    wr(6'h10, 8'h1F);
    hostMode = 1'b0;
    srcLevel[0] = ~srcLevel[0];
    idle(6);
    rdc(6'h14, 8'h00);
    hostMode = 1'b1;
    srcLevel[0] = ~srcLevel[0];
    idle(6);
    rdc(6'h14, 8'h01);
    for (int d = 0; d < 6; d++) begin
      srcLevel[1] = ~srcLevel[1];
      idle(d);
      rd(6'h14);
      v = rdVal;
      idle(6);
      rd(6'h14);
      chk(v | rdVal, 8'h02);
      chk(v & rdVal, 8'h00);
    end
    $display("test events done");
    wr(6'h19, 8'h0C);
    enterReq = 1'b1;
    @(posedge clk);
    #1 enterReq = 1'b0;
    for (int k = 0; k < 2; k++) begin
      uartTxIn = k[0];
      dpLevelIn = ~k[0];
      idle(5);
      chk({5'h0, dmOe, dmOut, data1Out}, {5'h0, 1'b1, k[0], ~k[0]});
      chk({7'h0, data1Oe}, 8'h01);
    end
    wr(6'h1B, 8'h08);
    idle(5);
    chk({7'h0, data1Out}, 8'h01);
    wr(6'h1A, 8'h02);
    idle(3);
    chk({7'h0, idPinGroundDrive}, 8'h01);
    carkitExit = 1'b1;
    @(posedge clk);
    #1 carkitExit = 1'b0;
    idle(2);
    chk({7'h0, accessoryUartSelect}, 8'h00);
    $display("test routing done");
    complete_run;
  end
endmodule
`default_nettype wire
